// [common/bwtop_pkg.sv]
// package: register map, field layout and types of the byte-wide timed output port
package bwtop_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_PIN_DATA = 8'h48;
  localparam logic [7:0] OFS_TIMING_SEL = 8'h4C;
  localparam logic [7:0] OFS_ALT_FUNC = 8'h4D;
  localparam logic [7:0] OFS_DRIVE_MODE = 8'h4E;
  localparam logic [7:0] OFS_DIRECTION = 8'h4F;
  localparam int SEL_HI_LSB = 4;
  localparam int SEL_LO_LSB = 0;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] RST_ALT_FUNC = 8'h00;
  localparam logic [1:0] RST_SEL = 2'h0;
  localparam logic [7:0] RST_UNDEF = 8'h00;
  localparam logic [1:0] SEL_HALF = 2'h0;
  localparam logic [1:0] SEL_TA1 = 2'h1;
  localparam logic [1:0] SEL_TB1 = 2'h2;
  localparam logic [1:0] SEL_TB2 = 2'h3;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wrData;
  } bwtop_bus_type;

  typedef struct packed {
    logic [7:0] pinOut;
    logic [7:0] pinOe;
  } bwtop_pins_type;

  typedef struct packed {
    logic eTxData;
    logic eTxClk;
    logic eRxClk;
    logic eTxClkOe;
    logic eRxClkOe;
    logic fTxData;
    logic fTxClk;
    logic fRxClk;
    logic fTxClkOe;
    logic fRxClkOe;
  } bwtop_serial_type;
endpackage : bwtop_pkg

// [hdl/bwtop_port.sv]
// byte-wide timed output port: registers, nibble update timing, drive and alternate functions
`timescale 1ns/100ps

// How it works
// - eight pins, each with its own direction
// - writes load buffer, pins update on edge
// - per-nibble timing select: clock or timers
// - default update timing is clock divided two
// - per-pin open-drain or push-pull drive
// - alternates carry serial and PWM signals
// - reset: all inputs, alternates disabled
// - direction and select fields reset zero
// - only data register reads back
// - no interrupt requests ever
// - select encoding, upper 5:4, lower 1:0
// - data read returns pin states
// - direction 1 output, drive 1 open-drain
module bwtop_port
  import bwtop_pkg::*;
#(
  parameter int PINS = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // register access
  input wire bwtop_bus_type bus,
  output logic [7:0] rdData,
  output logic rdValid,
  // pins
  input wire logic [PINS-1:0] pinIn,
  output bwtop_pins_type pins,
  // timer outputs
  input wire logic timerA1,
  input wire logic timerB1,
  input wire logic timerB2,
  // serial port E and F, PWM
  input wire bwtop_serial_type serialIn,
  input wire logic pwm1,
  input wire logic pwm0,
  output logic serialERxData,
  output logic serialFRxData,
  output logic serialERxClkIn,
  output logic serialETxClkIn,
  output logic serialFRxClkIn,
  output logic serialFTxClkIn
);

  initial begin
    if (PINS != 8) $error("bwtop_port serves exactly eight pins");
  end

  logic [7:0] buffer_r;
  logic [7:0] outData_r;
  logic [7:0] timingSel_r;
  logic [7:0] altFunc_r;
  logic [7:0] driveMode_r;
  logic [7:0] direction_r;
  logic halfDiv_r;
  logic [2:0] timerPrev_r;
  logic [7:0] rdData_r;
  logic rdValid_r;

  wire hitData = bus.addr == OFS_PIN_DATA;
  wire hitSel = bus.addr == OFS_TIMING_SEL;
  wire hitAlt = bus.addr == OFS_ALT_FUNC;
  wire hitDrive = bus.addr == OFS_DRIVE_MODE;
  wire hitDir = bus.addr == OFS_DIRECTION;

  // rising edge of each timer output, one cycle long
  wire [2:0] timerNow = {timerB2, timerB1, timerA1};
  wire [2:0] timerRise = timerNow & ~timerPrev_r;

  function automatic logic strobeOf(input logic [1:0] sel, input logic half, input logic [2:0] rise);
    logic s;
    s = 1'b0;
    case (sel)
      SEL_HALF: s = half;
      SEL_TA1: s = rise[0];
      SEL_TB1: s = rise[1];
      SEL_TB2: s = rise[2];
      default: s = 1'b0;
    endcase
    return s;
  endfunction : strobeOf

  // one decode per nibble
  wire updHi = strobeOf(timingSel_r[SEL_HI_LSB +: 2], halfDiv_r, timerRise);
  wire updLo = strobeOf(timingSel_r[SEL_LO_LSB +: 2], halfDiv_r, timerRise);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      halfDiv_r <= 1'b0;
      timerPrev_r <= 3'h0;
    end else begin
      halfDiv_r <= ~halfDiv_r;
      timerPrev_r <= timerNow;
    end
  end

  // control registers; registers with no defined reset still settle to a fixed value
  always_ff @(posedge clock) begin
    if (!rstn) begin
      direction_r <= RST_DIRECTION;
      altFunc_r <= RST_ALT_FUNC;
      timingSel_r <= RST_UNDEF;
      timingSel_r[SEL_HI_LSB +: 2] <= RST_SEL;
      timingSel_r[SEL_LO_LSB +: 2] <= RST_SEL;
      buffer_r <= RST_UNDEF;
      outData_r <= RST_UNDEF;
      driveMode_r <= RST_UNDEF;
    end else begin
      if (bus.wrEn && hitDir) direction_r <= bus.wrData;
      if (bus.wrEn && hitAlt) altFunc_r <= bus.wrData;
      if (bus.wrEn && hitSel) timingSel_r <= bus.wrData;
      if (bus.wrEn && hitData) buffer_r <= bus.wrData;
      if (bus.wrEn && hitDrive) driveMode_r <= bus.wrData;
      if (updHi) outData_r[7:4] <= buffer_r[7:4];
      if (updLo) outData_r[3:0] <= buffer_r[3:0];
    end
  end

  // alternate function per pin: pins 6 and 2 are outputs, pins 5, 4, 1 and 0 inputs or clock outputs, pins 7 and 3 inputs
  logic [7:0] srcData;
  logic [7:0] altDrives;
  assign srcData[7] = pwm1;
  assign srcData[6] = altFunc_r[6] ? serialIn.eTxData : outData_r[6];
  assign srcData[5] = serialIn.eRxClk;
  assign srcData[4] = altFunc_r[4] ? serialIn.eTxClk : outData_r[4];
  assign srcData[3] = pwm0;
  assign srcData[2] = altFunc_r[2] ? serialIn.fTxData : outData_r[2];
  assign srcData[1] = serialIn.fRxClk;
  assign srcData[0] = altFunc_r[0] ? serialIn.fTxClk : outData_r[0];
  assign altDrives[7] = 1'b0;
  assign altDrives[6] = altFunc_r[6];
  assign altDrives[5] = altFunc_r[5] & serialIn.eRxClkOe;
  assign altDrives[4] = altFunc_r[4] & serialIn.eTxClkOe;
  assign altDrives[3] = 1'b0;
  assign altDrives[2] = altFunc_r[2];
  assign altDrives[1] = altFunc_r[1] & serialIn.fRxClkOe;
  assign altDrives[0] = altFunc_r[0] & serialIn.fTxClkOe;

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : gPin
      wire isOutput = direction_r[g] | altDrives[g];
      // open-drain only pulls low; a high is left to the pull-up
      assign pins.pinOut[g] = srcData[g];
      assign pins.pinOe[g] = isOutput & (~driveMode_r[g] | ~srcData[g]);
    end
  endgenerate

  // receive paths see the pin only while enabled
  assign serialERxData = altFunc_r[7] & pinIn[7];
  assign serialERxClkIn = altFunc_r[5] & pinIn[5];
  assign serialETxClkIn = altFunc_r[4] & pinIn[4];
  assign serialFRxData = altFunc_r[3] & pinIn[3];
  assign serialFRxClkIn = altFunc_r[1] & pinIn[1];
  assign serialFTxClkIn = altFunc_r[0] & pinIn[0];

  // only the data register answers a read; write-only ones read zero
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdData_r <= 8'h00;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= bus.rdEn;
      rdData_r <= (bus.rdEn && hitData) ? pinIn : 8'h00;
    end
  end
  assign rdData = rdData_r;
  assign rdValid = rdValid_r;
  // no interrupt output exists at all

  a_dir_reset: assert property (@(posedge clock) !rstn |=> direction_r == RST_DIRECTION && altFunc_r == 8'h00)
    else $error("direction or alternate not cleared by reset");
  a_sel_reset: assert property (@(posedge clock) !rstn |=> timingSel_r[5:4] == 2'h0 && timingSel_r[1:0] == 2'h0)
    else $error("timing select not cleared by reset");
  a_hi_hold: assert property (@(posedge clock) disable iff (!rstn) !updHi |=> $stable(outData_r[7:4]))
    else $error("upper nibble moved without strobe");
  a_lo_load: assert property (@(posedge clock) disable iff (!rstn) updLo |=> outData_r[3:0] == $past(buffer_r[3:0]))
    else $error("lower nibble not loaded on strobe");
  a_half_rate: assert property (@(posedge clock) disable iff (!rstn)
    timingSel_r[1:0] == SEL_HALF && updLo |=> !updLo)
    else $error("default update faster than half clock");
  a_open_drain: assert property (@(posedge clock) disable iff (!rstn)
    driveMode_r[0] && pins.pinOe[0] |-> !pins.pinOut[0])
    else $error("open-drain pin driven high");
  a_input_quiet: assert property (@(posedge clock) disable iff (!rstn)
    !direction_r[2] && !altFunc_r[2] |-> !pins.pinOe[2])
    else $error("input pin driven");
  a_read_zero: assert property (@(posedge clock) disable iff (!rstn)
    bus.rdEn && !hitData |=> rdValid && rdData == 8'h00)
    else $error("write-only register read back");
  a_read_pins: assert property (@(posedge clock) disable iff (!rstn)
    bus.rdEn && hitData |=> rdData == $past(pinIn))
    else $error("data read not pin state");
  a_timer_strobe: assert property (@(posedge clock) disable iff (!rstn)
    timingSel_r[5:4] == SEL_TA1 && $stable(timingSel_r) && updHi |=> !updHi)
    else $error("timer strobe longer than one cycle");

  c_timer_update: cover property (@(posedge clock) disable iff (!rstn) timingSel_r[5:4] == SEL_TB2 && updHi);
  c_serial_tx: cover property (@(posedge clock) disable iff (!rstn) altFunc_r[6] && pins.pinOe[6]);
  c_data_write: cover property (@(posedge clock) disable iff (!rstn) bus.wrEn && hitData ##[1:4] updLo);

endmodule : bwtop_port

// [verif/bwtop_pin_model.sv]
// pin model: resolves each port pin against a board pull-up
`timescale 1ns/100ps
module bwtop_pin_model
  import bwtop_pkg::*;
(
  // pins of the port
  input wire bwtop_pins_type pins,
  output logic [7:0] pinIn
);
  // an undriven or open-drain high pin floats up, so a stale value never shows
  assign pinIn = (pins.pinOe & pins.pinOut) | ~pins.pinOe;
endmodule : bwtop_pin_model

// [verif/bwtop_port_tb_top.sv]
// testbench: register access, update timing, drive modes and reset of the port
`timescale 1ns/100ps
module bwtop_port_tb_top import bwtop_pkg::*;;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  bwtop_bus_type bus = '0;
  logic [2:0] tmr = 3'h0;
  logic [7:0] rdData;
  logic [7:0] pinIn;
  logic [7:0] d;
  logic rdValid;
  logic [5:0] serRx;
  bwtop_pins_type pins;
  int bad_count = 0;
  int n_checks = 0;
  always #10 clock = ~clock;
  bwtop_port dut (.clock(clock), .rstn(rstn), .bus(bus), .rdData(rdData), .rdValid(rdValid), .pinIn(pinIn),
    .pins(pins), .timerA1(tmr[0]), .timerB1(tmr[1]), .timerB2(tmr[2]), .serialIn('0), .pwm1(1'b0),
    .pwm0(1'b0), .serialERxData(serRx[5]), .serialFRxData(serRx[2]), .serialERxClkIn(serRx[4]),
    .serialETxClkIn(serRx[3]), .serialFRxClkIn(serRx[1]), .serialFTxClkIn(serRx[0]));
  bwtop_pin_model pm (.pins(pins), .pinIn(pinIn));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock) bus <= '{1'b1, 1'b0, a, v};
    @(posedge clock) bus <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock) bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock) bus <= '0;
    #1 chk("rdValid", 8'h01, {7'h00, rdValid});
    v = rdData;
  endtask : rd
  // pins 7,5,3,1 carry alternate signals, so only the even-pair pins are compared as data
  task automatic chkOut(input string nm, input logic [7:0] e);
    chk(nm, e, pins.pinOut & 8'h55);
  endtask : chkOut
  task automatic pulse(input int k);
    @(posedge clock) tmr[k] <= 1'b1;
    @(posedge clock) tmr[k] <= 1'b0;
    tick(3);
  endtask : pulse
  task automatic t_half;
    wr(OFS_DIRECTION, 8'h55);
    wr(OFS_DRIVE_MODE, 8'h00);
    wr(OFS_PIN_DATA, 8'h00);
    tick(4);
    wr(OFS_PIN_DATA, 8'hA5);
    #1 chkOut("pinOut early", 8'h00);
    tick(4);
    chkOut("pinOut half", 8'h05);
    chk("pinOe dir", 8'h55, pins.pinOe);
    rd(OFS_PIN_DATA, d);
    chk("pin read", 8'hAF, d);
  endtask : t_half
  task automatic t_timer;
    wr(OFS_TIMING_SEL, {2'h0, SEL_TB1, 2'h0, SEL_TA1});
    wr(OFS_PIN_DATA, 8'h50);
    tick(6);
    chkOut("pinOut held", 8'h05);
    pulse(0);
    chkOut("pinOut ta1", 8'h00);
    pulse(1);
    chkOut("pinOut tb1", 8'h50);
    wr(OFS_TIMING_SEL, {2'h0, SEL_TB2, 2'h0, SEL_TB2});
    wr(OFS_PIN_DATA, 8'h05);
    tick(4);
    chkOut("pinOut wait", 8'h50);
    pulse(2);
    chkOut("pinOut tb2", 8'h05);
  endtask : t_timer
  task automatic t_drain;
    wr(OFS_TIMING_SEL, {2'h0, SEL_HALF, 2'h0, SEL_HALF});
    wr(OFS_DRIVE_MODE, 8'h55);
    wr(OFS_PIN_DATA, 8'h50);
    tick(4);
    chk("pinOe drain", 8'h05, pins.pinOe);
    rd(OFS_PIN_DATA, d);
    chk("pin level", 8'hFA, d);
  endtask : t_drain
  task automatic t_wo;
    logic [7:0] aa [5];
    aa = '{OFS_TIMING_SEL, OFS_ALT_FUNC, OFS_DRIVE_MODE, OFS_DIRECTION, 8'h50};
    foreach (aa[i]) begin
      rd(aa[i], d);
      chk("write-only read", 8'h00, d);
    end
  endtask : t_wo
  // a second reset mid-run must drop every output and fall back to half-clock timing
  task automatic t_rst;
    wr(OFS_TIMING_SEL, 8'h33);
    @(posedge clock) rstn <= 1'b0;
    tick(2);
    @(posedge clock) rstn <= 1'b1;
    #1 chk("pinOe rst", 8'h00, pins.pinOe);
    wr(OFS_DRIVE_MODE, 8'h00);
    wr(OFS_DIRECTION, 8'h55);
    wr(OFS_PIN_DATA, 8'h05);
    tick(4);
    chkOut("pinOut sel rst", 8'h05);
  endtask : t_rst
  // serial receive paths follow their pins once enabled; pins 4 and 0 now carry idle serial clocks
  task automatic t_alt;
    wr(OFS_ALT_FUNC, 8'hBB);
    tick(1);
    chk("serial rx", 8'h36, {2'h0, serRx});
  endtask : t_alt
  task automatic results;
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  initial begin
    tick(20);
    @(posedge clock) rstn <= 1'b1;
    tick(1);
    chk("pinOe reset", 8'h00, pins.pinOe);
    t_half();
    t_timer();
    t_drain();
    t_wo();
    t_rst();
    t_alt();
    results();
  end
  // the tests need about 115 cycles; over twenty times that means a hang
  initial begin
    tick(3000);
    bad_count++;
    results();
  end
endmodule : bwtop_port_tb_top
